// ===== reset_wake_regs.svh
// Purpose: Offsets, field positions and reset values of the reset/wake block
// Assumes: Byte addresses on a 32-bit Avalon-MM slave
// Notes:   Included by the block's only design module
`ifndef RESET_WAKE_REGS_SVH
`define RESET_WAKE_REGS_SVH

`define OFS_CTRL      6'h00
`define OFS_CAUSE     6'h04
`define OFS_FLAGS     6'h08
`define OFS_STACK_TOP 6'h0c
`define OFS_STACK_PTR 6'h10
`define OFS_PA_PINS   6'h14
`define OFS_PA_LATCH  6'h18
`define OFS_PA_DIR    6'h1c
`define OFS_IRQ_STAT  6'h20
`define OFS_IRQ_MASK  6'h24

`define CTRL_RST      5'h00
`define CTRL_EN_HI    3
`define CTRL_EN_LO    4
`define CTRL_XCLR_DIS 2

`define CAUSE_POR_RST 5'h1c
`define CS_BOR        0
`define CS_POR        1
`define CS_PD         2
`define CS_TO         3
`define CS_RI         4

`define VEC_HIGH      21'h000008
`define VEC_LOW       21'h000018
`define PC_STEP       21'h000002

`define SP_RST        5'h00
`define SP_FULL       7
`define SP_UNF        6
`define PA_DIR_RST    8'hff
`define PA_BIT5       5
`define PA_BIT6       6
`define PA_BIT7       7
`define PA_LOW_MASK   8'h1f
`define OSC_BOTH_IO   2'h2
`define OSC_BIT6_IO   2'h1

`define EV_RESET      0
`define EV_WAKE       1
`define EV_VECTOR     2
`define EV_STKOVF     3
`define FLAG_DEFAULT  0

`endif

// ===== reset_wake_pkg.sv
// Purpose: Types shared by the reset/wake register-init block
// Assumes: Constants live in reset_wake_regs.svh
// Notes:   Categories and carriers only
package reset_wake_pkg;

   typedef enum logic [1:0] {CAT_NONE, CAT_POWER, CAT_OTHER, CAT_WAKE} cat_t;

   typedef struct packed {
      logic [4:0] upper;
      logic [7:0] high;
      logic [7:0] low;
   } stack_top_t;

   typedef struct packed {
      logic [7:0] periph;
      logic [7:0] intr;
   } wake_flags_t;

   typedef struct packed {
      logic [1:0] osc_mode;
      logic       osc_ready;
   } osc_ctrl_t;

endpackage

// ===== reset_wake_init.sv
// Purpose: Applies register initial values by reset or wake-up cause
// Assumes: Cause pulses come from core logic on clk_i; pins are asynchronous
// Notes:   Avalon-MM slave, one wait state on every access
`timescale 1ns/100ps
`include "reset_wake_regs.svh"

// Functional notes
// RL1: Wake-up sets at least one flag bit; here only an interrupt wake sets flags, a watchdog wake sets none
// RL2: Interrupt wake with enable loads vector address
// RL3: Same wake copies PC into stack top
// RL4: Same wake advances the stack pointer
// RL5: Oscillator mode enables port A bits 6,7
// RL6: Disabled port A bits read zero
// RL7: Port A bit 5 only when master-clear disabled
// RL8: Unimplemented bits always read zero
// RL9: Unchanged bits keep value; unknown bits free
// RL10: Cause and oscillator status bits depend on event
// RL11: Three categories select the initial values
module reset_wake_init
   import reset_wake_pkg::*;
#(
   parameter int SP_W = 5
) (
   input  wire logic        clk_i,                 // 250 MHz core clock
   input  wire logic        rst_b_i,               // Power-on reset, async, low
   input  wire logic [5:0]  avs_address,           // Byte address
   input  wire logic        avs_read,              // Read request
   input  wire logic        avs_write,             // Write request
   input  wire logic [31:0] avs_writedata,         // Write data
   output logic      [31:0] avs_readdata,          // Read data
   output logic             avs_waitrequest,       // Stall
   input  wire logic        bor_i,                 // Brown-out pulse
   input  wire logic        wdt_i,                 // Watchdog pulse
   input  wire logic        reset_instr_i,         // Reset instruction pulse
   input  wire logic        stack_rst_i,           // Stack reset pulse
   input  wire logic        wake_wdt_i,            // Watchdog wake pulse
   input  wire logic        wake_irq_i,            // Interrupt wake pulse
   input  wire logic        irq_high_i,            // Wake interrupt is high priority
   input  wire wake_flags_t wake_src_i,            // Flag sources of the wake
   input  wire logic [20:0] pc_i,                  // Current program counter
   input  wire logic        osc_ready_i,           // Oscillator stable level
   input  wire logic        master_clear_input_b_i, // Master-clear pin, low
   input  wire logic [7:0]  port_a_pins_i,         // Port A pin levels
   output logic      [7:0]  port_a_out_o,          // Port A drive value
   output logic      [7:0]  port_a_oe_b_o,         // Port A enable, low drives
   output logic             pc_load_o,             // PC load strobe
   output logic      [20:0] pc_value_o,            // PC value to load
   output cat_t             cat_o,                 // Last applied category
   output logic             irq_o                  // Level interrupt
);

   if (SP_W < 2 || SP_W > 6) $error("SP_W out of range");

   logic [1:0] xclr_sync_r;
   logic [7:0] pa_s1_r;
   logic [7:0] pa_s2_r;
   logic       xclr_prev_r;
   logic [4:0] ctrl_r;
   logic [4:0] cause_r;
   osc_ctrl_t  osc_r;
   wake_flags_t flags_r;
   stack_top_t tos_r;
   logic [SP_W-1:0] sp_r;
   logic       sp_full_r;
   logic       sp_unf_r;
   logic [7:0] pa_latch_r;
   logic [7:0] pa_dir_r;
   logic [3:0] irq_stat_r;
   logic [3:0] irq_mask_r;
   logic       ack_r;
   logic [31:0] rdata_r;
   logic       pc_load_r;
   logic [20:0] pc_value_r;
   cat_t       cat_r;
   logic       xclr_ev;
   logic       other_ev;
   logic       wake_ev;
   logic       vector_ev;
   logic       sp_ovf;
   logic       wr_go;
   logic [7:0] pa_mask;
   logic [3:0] ev_vec;
   cat_t       cat_nxt;

   // Port A bits that exist in the current configuration
   function automatic logic [7:0] pa_enable(input logic [1:0] mode, input logic xclr_dis);
      logic [7:0] m;
      m                = `PA_LOW_MASK;
      m[`PA_BIT5]      = xclr_dis;                                   // see RL7
      m[`PA_BIT6]      = (mode == `OSC_BOTH_IO) || (mode == `OSC_BIT6_IO); // see RL5
      m[`PA_BIT7]      = (mode == `OSC_BOTH_IO);                     // see RL5
      return m;
   endfunction

   // Two-stage synchronisers for pins
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         xclr_sync_r <= 2'h3;
         pa_s1_r     <= 8'h00;
         pa_s2_r     <= 8'h00;
         xclr_prev_r <= 1'h1;
      end else begin
         xclr_sync_r <= {xclr_sync_r[0], master_clear_input_b_i};
         pa_s1_r     <= port_a_pins_i;
         pa_s2_r     <= pa_s1_r;
         xclr_prev_r <= xclr_sync_r[1];
      end
   end

   assign pa_mask   = pa_enable(osc_r.osc_mode, ctrl_r[`CTRL_XCLR_DIS]);
   assign xclr_ev   = xclr_prev_r && !xclr_sync_r[1] && !ctrl_r[`CTRL_XCLR_DIS];
   assign other_ev  = xclr_ev || wdt_i || reset_instr_i || stack_rst_i;
   assign wake_ev   = !bor_i && !other_ev && (wake_wdt_i || wake_irq_i);
   assign vector_ev = wake_ev && wake_irq_i && (ctrl_r[`CTRL_EN_HI] || ctrl_r[`CTRL_EN_LO]);
   assign sp_ovf    = vector_ev && (&sp_r);

   // Category of the event in this cycle
   always_comb begin
      if (bor_i) begin
         cat_nxt = CAT_POWER;                                        // see RL11
      end else if (other_ev) begin
         cat_nxt = CAT_OTHER;                                        // see RL11
      end else if (wake_ev) begin
         cat_nxt = CAT_WAKE;                                         // see RL11
      end else begin
         cat_nxt = CAT_NONE;
      end
   end
   assign wr_go = avs_write && ack_r;

   // Control: osc mode, master-clear disable, global enables
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl_r <= `CTRL_RST;
         osc_r  <= '0;
      end else begin
         unique case (cat_nxt)
            CAT_POWER, CAT_OTHER: begin
               ctrl_r[`CTRL_EN_HI] <= 1'h0;
               ctrl_r[`CTRL_EN_LO] <= 1'h0;
               osc_r.osc_mode     <= 2'h0;
               osc_r.osc_ready    <= osc_ready_i;                    // see RL10
            end
            CAT_WAKE: begin
               osc_r.osc_ready <= osc_ready_i;                       // see RL10
            end
            CAT_NONE: begin
               if (wr_go && avs_address == `OFS_CTRL) begin
                  ctrl_r         <= avs_writedata[4:0];
                  osc_r.osc_mode <= avs_writedata[6:5];
               end
            end
         endcase
      end
   end

   // Reset cause bits, active low like the classic status flags
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cause_r <= `CAUSE_POR_RST;
      end else if (bor_i) begin
         cause_r[`CS_BOR] <= 1'h0;                                   // see RL10
         cause_r[`CS_POR] <= 1'h1;
         cause_r[`CS_TO]  <= 1'h1;
         cause_r[`CS_PD]  <= 1'h1;
      end else if (other_ev) begin
         if (reset_instr_i) cause_r[`CS_RI] <= 1'h0;                 // see RL10
         if (wdt_i)         cause_r[`CS_TO] <= 1'h0;                 // see RL10
         if (xclr_ev)       cause_r[`CS_TO] <= 1'h1;
      end else if (wake_ev) begin
         cause_r[`CS_PD] <= 1'h0;                                    // see RL10
         if (wake_wdt_i) cause_r[`CS_TO] <= 1'h0;                    // see RL10
      end else if (wr_go && avs_address == `OFS_CAUSE) begin
         cause_r <= avs_writedata[4:0];
      end
   end

   // Wake flags: sources set, software clears by writing one; set wins
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         flags_r <= '0;
      end else begin
         flags_r <= (cat_nxt inside {CAT_POWER, CAT_OTHER}) ? '0 :
                    (flags_r & ~((wr_go && avs_address == `OFS_FLAGS) ?
                                 avs_writedata[15:0] : 16'h0000));
         if (wake_ev && wake_irq_i) begin
            flags_r <= flags_r | wake_src_i;                         // see RL1
            if (wake_src_i == '0) flags_r.intr[`FLAG_DEFAULT] <= 1'h1; // see RL1
         end
      end
   end

   // Stack top and pointer
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tos_r     <= '0;
         sp_r      <= SP_W'(`SP_RST);
         sp_full_r <= 1'h0;
         sp_unf_r  <= 1'h0;
      end else if (cat_nxt == CAT_POWER || cat_nxt == CAT_OTHER) begin
         tos_r <= '0;                                                // see RL11
         sp_r  <= SP_W'(`SP_RST);
         if (cat_nxt == CAT_POWER) begin
            sp_full_r <= 1'h0;
            sp_unf_r  <= 1'h0;
         end else if (stack_rst_i) begin
            sp_unf_r  <= sp_unf_r | (sp_r == '0);                    // see RL10
            sp_full_r <= sp_full_r | (sp_r != '0);                   // see RL10
         end
      end else if (vector_ev) begin
         tos_r <= pc_i;                                              // see RL3
         sp_r  <= sp_r + SP_W'(1);                                   // see RL4
         if (sp_ovf) sp_full_r <= 1'h1;
      end else if (wr_go && avs_address == `OFS_STACK_PTR) begin
         sp_r      <= avs_writedata[SP_W-1:0];
         sp_full_r <= sp_full_r & ~avs_writedata[`SP_FULL];
         sp_unf_r  <= sp_unf_r & ~avs_writedata[`SP_UNF];
      end
   end

   // PC load strobe for reset vector, wake return or interrupt vector
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pc_load_r  <= 1'h0;
         pc_value_r <= '0;
         cat_r      <= CAT_POWER;
      end else begin
         pc_load_r <= (cat_nxt != CAT_NONE);
         if (cat_nxt != CAT_NONE) cat_r <= cat_nxt;
         if (vector_ev) begin
            pc_value_r <= irq_high_i ? `VEC_HIGH : `VEC_LOW;         // see RL2
         end else if (cat_nxt == CAT_WAKE) begin
            pc_value_r <= pc_i + `PC_STEP;
         end else if (cat_nxt != CAT_NONE) begin
            pc_value_r <= '0;
         end
      end
   end

   // Port A latch and direction; unchanged on wake
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pa_latch_r <= 8'h00;
         pa_dir_r   <= `PA_DIR_RST;
      end else if (cat_nxt == CAT_POWER || cat_nxt == CAT_OTHER) begin
         pa_dir_r <= `PA_DIR_RST;                                    // see RL9
      end else if (wr_go && cat_nxt == CAT_NONE && avs_address == `OFS_PA_LATCH) begin
         pa_latch_r <= avs_writedata[7:0];
      end else if (wr_go && cat_nxt == CAT_NONE && avs_address == `OFS_PA_DIR) begin
         pa_dir_r <= avs_writedata[7:0];
      end
   end

   assign port_a_out_o  = pa_latch_r & pa_mask;                      // see RL6
   assign port_a_oe_b_o = pa_dir_r | ~pa_mask;                       // see RL5

   // Interrupt status, write one to clear, set wins
   assign ev_vec = {sp_ovf, vector_ev, wake_ev, bor_i || other_ev};
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_stat_r <= 4'h0;
         irq_mask_r <= 4'h0;
      end else begin
         irq_stat_r <= ev_vec | (irq_stat_r &
                       ~((wr_go && avs_address == `OFS_IRQ_STAT) ? avs_writedata[3:0] : 4'h0));
         if (wr_go && avs_address == `OFS_IRQ_MASK) irq_mask_r <= avs_writedata[3:0];
      end
   end

   assign irq_o = |(irq_stat_r & irq_mask_r);

   // Bus: data latched on first cycle, answered on second
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ack_r   <= 1'h0;
         rdata_r <= 32'h00000000;
      end else begin
         ack_r   <= (avs_read || avs_write) && !ack_r;
         rdata_r <= 32'h00000000;                                    // see RL8
         if (avs_read && !ack_r) begin
            unique case (avs_address)
               `OFS_CTRL:      rdata_r[6:0]  <= {osc_r.osc_mode, ctrl_r};
               `OFS_CAUSE:     rdata_r[5:0]  <= {osc_r.osc_ready, cause_r};
               `OFS_FLAGS:     rdata_r[15:0] <= flags_r;
               `OFS_STACK_TOP: rdata_r[20:0] <= tos_r;
               `OFS_STACK_PTR: begin
                  rdata_r[SP_W-1:0] <= sp_r;
                  rdata_r[`SP_FULL] <= sp_full_r;
                  rdata_r[`SP_UNF]  <= sp_unf_r;
               end
               `OFS_PA_PINS:   rdata_r[7:0]  <= pa_s2_r & pa_mask;   // see RL6
               `OFS_PA_LATCH:  rdata_r[7:0]  <= pa_latch_r & pa_mask;
               `OFS_PA_DIR:    rdata_r[7:0]  <= pa_dir_r & pa_mask;
               `OFS_IRQ_STAT:  rdata_r[3:0]  <= irq_stat_r;
               `OFS_IRQ_MASK:  rdata_r[3:0]  <= irq_mask_r;
               default:        rdata_r       <= 32'h00000000;
            endcase
         end
      end
   end

   assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
   assign avs_readdata    = rdata_r;
   assign pc_load_o       = pc_load_r;
   assign pc_value_o      = pc_value_r;
   assign cat_o           = cat_r;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   sequence s_vec_wake;
      vector_ev ##0 irq_high_i;
   endsequence

   AST_VEC_HIGH: assert property (s_vec_wake |=> pc_load_o && pc_value_o == `VEC_HIGH) // see RL2
      else $error("high vector not loaded");
   AST_VEC_LOW: assert property (vector_ev && !irq_high_i |=> pc_value_o == `VEC_LOW) // see RL2
      else $error("low vector not loaded");
   AST_TOS_COPY: assert property (vector_ev |=> tos_r == $past(pc_i)) // see RL3
      else $error("stack top not copied");
   AST_SP_STEP: assert property (vector_ev |=> sp_r == $past(sp_r) + SP_W'(1)) // see RL4
      else $error("stack pointer not advanced");
   AST_WAKE_FLAG: assert property (wake_ev && wake_irq_i |=> flags_r != '0) // see RL1
      else $error("no wake flag set");
   AST_PA_MASK: assert property (osc_r.osc_mode != `OSC_BOTH_IO // see RL6
                                 |-> !port_a_out_o[`PA_BIT7] && port_a_oe_b_o[`PA_BIT7])
      else $error("disabled port bit driven");
   AST_PA_BIT5: assert property (!ctrl_r[`CTRL_XCLR_DIS] |-> port_a_oe_b_o[`PA_BIT5]) // see RL7
      else $error("bit 5 enabled with master clear");
   AST_RD_ZERO: assert property (avs_read && avs_address == `OFS_IRQ_MASK && !ack_r
                                 |=> avs_readdata[31:4] == '0) // see RL8
      else $error("unimplemented bits nonzero");
   AST_WAKE_KEEP: assert property (cat_nxt == CAT_WAKE |=> $stable(pa_latch_r)) // see RL9
      else $error("latch changed on wake");
   AST_CAUSE_PD: assert property (wake_ev |=> !cause_r[`CS_PD]) // see RL10
      else $error("power-down bit not cleared on wake");
   AST_CAT_RESET: assert property (other_ev && !bor_i // see RL11
                                   |=> cat_o == CAT_OTHER ##0 sp_r == '0)
      else $error("other reset not applied");

endmodule

// ===== reset_wake_init_tb_top.sv
// Purpose: Self-checking bench for the reset/wake register-init block
// Assumes: One wait state per Avalon access; event pulses drive ports directly
// Notes:   Random ctrl, PC, flag sources and pins from a fixed seed
`timescale 1ns/100ps
`include "reset_wake_regs.svh"
module reset_wake_init_tb_top;
   import reset_wake_pkg::*;
   logic        clk_i;
   logic        rst_b_i;
   logic [5:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [5:0]  ev;
   logic        irq_high;
   wake_flags_t wake_src;
   logic [20:0] pc;
   logic        osc_ready;
   logic        xclr_b;
   logic [7:0]  pins;
   logic [7:0]  port_a_out_o;
   logic [7:0]  port_a_oe_b_o;
   logic        pc_load_o;
   logic [20:0] pc_value_o;
   cat_t        cat_o;
   logic        irq_o;
   int          fail_count;
   int          checks_done;
   int          cyc;
   int          seed;

   reset_wake_init i_dut (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .bor_i(ev[0]), .wdt_i(ev[1]),
      .reset_instr_i(ev[2]), .stack_rst_i(ev[3]), .wake_wdt_i(ev[4]), .wake_irq_i(ev[5]),
      .irq_high_i(irq_high), .wake_src_i(wake_src), .pc_i(pc), .osc_ready_i(osc_ready),
      .master_clear_input_b_i(xclr_b), .port_a_pins_i(pins), .port_a_out_o(port_a_out_o),
      .port_a_oe_b_o(port_a_oe_b_o), .pc_load_o(pc_load_o), .pc_value_o(pc_value_o),
      .cat_o(cat_o), .irq_o(irq_o));

   always #2 clk_i = ~clk_i;

   task automatic stop_test();
      if (fail_count == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         stop_test();
      end
   end

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !w;
      avs_write <= w;
      @(posedge clk_i);
      while (avs_waitrequest !== 1'b0)
         @(posedge clk_i);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk_i);
   endtask

   // Pulse at one edge; registered answer is sampled at the next
   task automatic fire(input logic [5:0] e);
      ev <= e;
      @(posedge clk_i);
      ev <= 6'h00;
      @(posedge clk_i);
   endtask

   function automatic logic [7:0] pa_mask(input logic [6:0] c);
      logic [7:0] m;
      m = `PA_LOW_MASK;
      if (c[`CTRL_XCLR_DIS])
         m[`PA_BIT5] = 1'b1;
      if (c[6:5] == `OSC_BOTH_IO)
         m[7:6] = 2'h3;
      if (c[6:5] == `OSC_BIT6_IO)
         m[`PA_BIT6] = 1'b1;
      return m;
   endfunction

   logic [31:0] q;
   logic [31:0] unused_q;
   logic [6:0]  ctrl;
   logic [7:0]  m;
   logic [4:0]  sp0;
   logic        vec;
   logic [15:0] fexp;
   logic [5:0]  kev [4] = '{6'h02, 6'h04, 6'h01, 6'h08};
   int          kbit [4] = '{`CS_TO, `CS_RI, `CS_BOR, 0};
   int          n;

   initial begin
      seed = 32'hd0234fc7;
      clk_i = 1'b0;
      rst_b_i = 1'b0;
      {avs_address, avs_read, avs_write, avs_writedata} = '0;
      ev = 6'h00;
      irq_high = 1'b0;
      wake_src = '0;
      pc = 21'h000000;
      osc_ready = 1'b1;
      xclr_b = 1'b1;
      pins = 8'h00;
      fail_count = 0;
      checks_done = 0;
      cyc = 0;
      repeat (5) @(posedge clk_i);
      rst_b_i <= 1'b1;
      @(posedge clk_i);
      chk("cat_por", {30'h0, cat_o}, {30'h0, CAT_POWER});
      bus(1'b0, `OFS_CAUSE, 32'h0, q);
      chk("cause_por", {27'h0, q[4:0]}, {27'h0, `CAUSE_POR_RST});
      bus(1'b0, `OFS_STACK_PTR, 32'h0, q);
      chk("sp_por", q, 32'h0);
      bus(1'b1, 6'h28, 32'hffffffff, unused_q);
      bus(1'b0, 6'h28, 32'h0, q);
      chk("unmapped", q, 32'h0);
      for (int i = 0; i < 8; i++) begin
         ctrl = 7'($random(seed));
         ctrl[6:5] = 2'(i);
         m = pa_mask(ctrl);
         pins <= 8'($random(seed));
         bus(1'b1, `OFS_CTRL, {25'h0, ctrl}, unused_q);
         bus(1'b1, `OFS_PA_LATCH, 32'hff, unused_q);
         bus(1'b1, `OFS_PA_DIR, 32'h00, unused_q);
         bus(1'b0, `OFS_PA_PINS, 32'h0, q);
         chk("pa_pins", q, {24'h0, pins & m});
         bus(1'b0, `OFS_PA_LATCH, 32'h0, q);
         chk("pa_latch", q, {24'h0, m});
         chk("pa_out", {24'h0, port_a_out_o}, {24'h0, m});
         chk("pa_oe_b", {24'h0, port_a_oe_b_o}, {24'h0, ~m});
         bus(1'b1, `OFS_FLAGS, 32'hffff, unused_q);
         bus(1'b1, `OFS_IRQ_STAT, 32'hf, unused_q);
         bus(1'b0, `OFS_STACK_PTR, 32'h0, q);
         sp0 = q[4:0];
         pc <= 21'($random(seed));
         wake_src <= (i == 0) ? 16'h0000 : 16'($random(seed));
         irq_high <= 1'($random(seed));
         osc_ready <= 1'($random(seed));
         @(posedge clk_i);
         vec = ctrl[`CTRL_EN_HI] | ctrl[`CTRL_EN_LO];
         fire(6'h20);
         chk("pc_load", {31'h0, pc_load_o}, 32'h1);
         chk("pc_value", {11'h0, pc_value_o},
             {11'h0, vec ? (irq_high ? `VEC_HIGH : `VEC_LOW) : pc + `PC_STEP});
         chk("cat_wake", {30'h0, cat_o}, {30'h0, CAT_WAKE});
         bus(1'b0, `OFS_STACK_TOP, 32'h0, q);
         if (vec)
            chk("stack_top", q, {11'h0, pc});
         bus(1'b0, `OFS_STACK_PTR, 32'h0, q);
         chk("stack_ptr", {27'h0, q[4:0]}, {27'h0, sp0 + 5'(vec)});
         fexp = (wake_src == 16'h0) ? 16'h0001 : wake_src;
         bus(1'b0, `OFS_FLAGS, 32'h0, q);
         chk("flags", q, {16'h0, fexp});
         bus(1'b0, `OFS_IRQ_STAT, 32'h0, q);
         chk("irq_stat", {30'h0, q[2:1]}, {30'h0, vec, 1'b1});
         fire(kev[i % 4]);
         chk("pc_reset", {11'h0, pc_value_o}, 32'h0);
         chk("cat_reset", {30'h0, cat_o},
             {30'h0, (i % 4 == 2) ? CAT_POWER : CAT_OTHER});
         bus(1'b0, `OFS_CAUSE, 32'h0, q);
         if (i % 4 != 3)
            chk("cause_bit", {31'h0, q[kbit[i % 4]]}, 32'h0);
         chk("cause_osc", {31'h0, q[5]}, {31'h0, osc_ready});
         bus(1'b0, `OFS_CTRL, 32'h0, q);
         chk("ctrl_reset", {28'h0, q[6:3]}, 32'h0);
         bus(1'b0, `OFS_STACK_PTR, 32'h0, q);
         chk("sp_reset", {27'h0, q[4:0]}, 32'h0);
         if (i % 4 == 3)
            chk("stack_flags", {30'h0, q[7:6]},
                {30'h0, ((sp0 + 5'(vec)) == 5'h00) ? 2'h1 : 2'h2});
         bus(1'b0, `OFS_PA_DIR, 32'h0, q);
         chk("dir_reset", q,
             {24'h0, `PA_DIR_RST & pa_mask({4'h0, ctrl[`CTRL_XCLR_DIS], 2'h0})});
      end
      bus(1'b1, `OFS_IRQ_STAT, 32'hf, unused_q);
      bus(1'b1, `OFS_IRQ_MASK, 32'h2, unused_q);
      fire(6'h20);
      bus(1'b0, `OFS_IRQ_MASK, 32'h0, q);
      chk("irq_mask_rd", q, 32'h2);
      chk("irq_on", {31'h0, irq_o}, 32'h1);
      bus(1'b1, `OFS_IRQ_STAT, 32'h2, unused_q);
      @(posedge clk_i);
      chk("irq_clr", {31'h0, irq_o}, 32'h0);
      bus(1'b1, `OFS_IRQ_MASK, 32'h0, unused_q);
      fire(6'h20);
      @(posedge clk_i);
      chk("irq_masked", {31'h0, irq_o}, 32'h0);
      fire(6'h10);
      chk("pc_wdt_wake", {11'h0, pc_value_o}, {11'h0, pc + `PC_STEP});
      bus(1'b0, `OFS_CAUSE, 32'h0, q);
      chk("cause_wdt_wake", {30'h0, q[3:2]}, 32'h0);
      bus(1'b1, `OFS_CTRL, 32'h0, unused_q);
      xclr_b <= 1'b0;
      n = 0;
      @(posedge clk_i);
      while (pc_load_o !== 1'b1 && n < 10) begin
         n++;
         @(posedge clk_i);
      end
      chk("xclr_load", {31'h0, pc_load_o}, 32'h1);
      chk("xclr_cat", {30'h0, cat_o}, {30'h0, CAT_OTHER});
      xclr_b <= 1'b1;
      repeat (4) @(posedge clk_i);
      bus(1'b0, `OFS_CAUSE, 32'h0, q);
      chk("xclr_to", {31'h0, q[`CS_TO]}, 32'h1);
      stop_test();
   end
endmodule
